// ---- logic/asr_adc_ctrl.v ----
// Purpose: Status/control, result formatting and pin enables of a 10-bit SAR converter
// Assumes: Analog core seen as start/abort request plus done pulse with a 10-bit code
// Notes: Register reach is Avalon-MM with waitrequest, one wait state per access
//
// Local design decisions: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "asr_defs.vh"

module asr_adc_ctrl #(
    parameter CODE_W = 10,
    parameter PIN_N = 8
) (
    input wire i_clk_sys,
    input wire i_srst,
    // Avalon-MM slave
    input wire [`ASR_ADDR_W-1:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output reg o_avs_waitrequest,
    output reg [1:0] o_avs_response,
    // Analog core
    output reg o_core_start,
    output reg o_core_abort,
    output reg [1:0] o_core_source,
    output reg [2:0] o_core_pin,
    input wire i_core_done,
    input wire [CODE_W-1:0] i_core_code,
    // Status to the system
    output reg o_irq,
    output reg o_busy,
    output reg [PIN_N-1:0] o_pin_analog_en
);

    reg [7:0] main_ctrl_q;
    reg [7:0] status_ctrl_q;
    reg [PIN_N-1:0] pin_enable_q;
    reg [7:0] result_upper_q;
    reg [7:0] result_lower_q;
    reg busy_q;
    reg ack_q;
    reg [1:0] src_d;
    reg [7:0] up_d;
    reg [7:0] lo_d;
    reg [7:0] rdata_d;
    reg hit_d;

    wire acc = (i_avs_read | i_avs_write) & ~ack_q;
    // Effects land on the edge where the master sees waitrequest low
    wire wr = i_avs_write & ack_q & i_avs_byteenable[0];
    wire rd = i_avs_read & ack_q;
    // Main control shares offset 0 with pin enable; write data bit 31 set selects main control, clear selects pin enable
    wire wr_main = wr & (i_avs_address == `ASR_OFF_MAIN_CTRL) & i_avs_writedata[31];
    wire wr_pe = wr & (i_avs_address == `ASR_OFF_PIN_ENABLE) & ~i_avs_writedata[31];
    wire wr_sc = wr & (i_avs_address == `ASR_OFF_STATUS_CTRL);
    wire rd_res = rd & ((i_avs_address == `ASR_OFF_RESULT_UPPER) |
        (i_avs_address == `ASR_OFF_RESULT_LOWER));
    wire [4:0] sel = status_ctrl_q[`ASR_SEL_HI:`ASR_SEL_LO];
    wire [4:0] sel_new = i_avs_writedata[`ASR_SEL_HI:`ASR_SEL_LO];
    wire fin = busy_q & i_core_done;

    // Source chosen from the selection code and pin enables
    function [1:0] pick_src;
        input [4:0] code;
        input [PIN_N-1:0] pe;
        begin
            if (code <= `ASR_CH_LAST_EXT) begin
                pick_src = pe[code[2:0]] ? `ASR_SRC_PIN : `ASR_SRC_REF_LOW;
            end else if (code == `ASR_CH_REF_HIGH) begin
                pick_src = `ASR_SRC_REF_HIGH;
            end else begin
                pick_src = `ASR_SRC_REF_LOW;
            end
        end
    endfunction

    always @* begin
        src_d = pick_src(sel_new, pin_enable_q);
    end

    // Result formatting
    always @* begin
        up_d = 8'h00;
        lo_d = 8'h00;
        if (main_ctrl_q[`ASR_BIT_EIGHT]) begin
            up_d = i_core_code[9:2];
        end else if (main_ctrl_q[`ASR_BIT_JUSTIFY]) begin
            up_d = {6'h00, i_core_code[9:8]};
            lo_d = i_core_code[7:0];
        end else begin
            up_d = i_core_code[9:2];
            lo_d = {i_core_code[1:0], 6'h00};
        end
        // Signed only when left justified
        if (!main_ctrl_q[`ASR_BIT_JUSTIFY]) begin
            if (main_ctrl_q[`ASR_BIT_SIGNED]) begin
                up_d[7] = ~up_d[7];
            end
        end
    end

    always @* begin
        hit_d = 1'b1;
        case (i_avs_address)
            `ASR_OFF_PIN_ENABLE: rdata_d = pin_enable_q;
            `ASR_OFF_STATUS_CTRL: rdata_d = status_ctrl_q;
            `ASR_OFF_RESULT_UPPER: rdata_d = result_upper_q;
            `ASR_OFF_RESULT_LOWER: rdata_d = result_lower_q;
            default: begin
                rdata_d = 8'h00;
                hit_d = 1'b0;
            end
        endcase
    end

    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            main_ctrl_q <= `ASR_RST_MAIN;
            status_ctrl_q <= `ASR_RST_SC;
            pin_enable_q <= `ASR_RST_PE;
            result_upper_q <= `ASR_RST_RESULT;
            result_lower_q <= `ASR_RST_RESULT;
            busy_q <= 1'b0;
            ack_q <= 1'b0;
            o_avs_readdata <= `ASR_UNMAPPED_DATA;
            o_avs_waitrequest <= 1'b1;
            o_avs_response <= 2'b00;
            o_core_start <= 1'b0;
            o_core_abort <= 1'b0;
            o_core_source <= `ASR_SRC_REF_LOW;
            o_core_pin <= 3'h0;
            o_irq <= 1'b0;
            o_busy <= 1'b0;
            o_pin_analog_en <= `ASR_RST_PE;
        end else begin
            ack_q <= acc;
            o_avs_waitrequest <= ~acc;
            o_avs_readdata <= {24'h000000, rdata_d};
            o_avs_response <= hit_d ? 2'b00 : 2'b10;
            o_core_start <= 1'b0;
            o_core_abort <= 1'b0;
            if (fin) begin
                result_upper_q <= up_d;
                result_lower_q <= lo_d;
                status_ctrl_q[`ASR_BIT_DONE] <= 1'b1;
                if (status_ctrl_q[`ASR_BIT_CONT]) begin
                    o_core_start <= 1'b1;
                    o_core_source <= pick_src(sel, pin_enable_q);
                    o_core_pin <= sel[2:0];
                end else begin
                    busy_q <= 1'b0;
                end
            end else if (rd_res) begin
                status_ctrl_q[`ASR_BIT_DONE] <= 1'b0;
            end
            if (wr_sc) begin
                // Bit 7 is read-only; a write clears it and restarts
                status_ctrl_q <= {1'b0, i_avs_writedata[6:0]};
                busy_q <= 1'b1;
                o_core_abort <= busy_q;
                o_core_start <= 1'b1;
                o_core_source <= src_d;
                o_core_pin <= sel_new[2:0];
            end else if (wr_main || wr_pe) begin
                busy_q <= 1'b0;
                o_core_abort <= busy_q;
                o_core_start <= 1'b0;
            end
            if (wr_main) begin
                main_ctrl_q <= i_avs_writedata[7:0];
            end
            if (wr_pe) begin
                pin_enable_q <= i_avs_writedata[PIN_N-1:0];
                o_pin_analog_en <= i_avs_writedata[PIN_N-1:0];
            end
            // Results ignore writes entirely
            o_irq <= status_ctrl_q[`ASR_BIT_IRQ_EN] & status_ctrl_q[`ASR_BIT_DONE];
            o_busy <= busy_q;
        end
    end

endmodule // asr_adc_ctrl
`default_nettype wire

// ---- logic/asr_defs.vh ----
// Purpose: Register map, field positions and reset values for the converter control block
// Assumes: Avalon-MM word addressing by byte address, 32-bit data, low 8 bits used, plus bit 31 on writes to offset 0 to pick main control over pin enable
// Notes: Definitions only
`ifndef ASR_DEFS_VH
`define ASR_DEFS_VH

`define ASR_ADDR_W 4
`define ASR_OFF_MAIN_CTRL 4'h0
`define ASR_OFF_STATUS_CTRL 4'h4
`define ASR_OFF_RESULT_UPPER 4'h8
`define ASR_OFF_RESULT_LOWER 4'hc
`define ASR_OFF_PIN_ENABLE 4'h0

`define ASR_BIT_DONE 7
`define ASR_BIT_IRQ_EN 6
`define ASR_BIT_CONT 5
`define ASR_SEL_HI 4
`define ASR_SEL_LO 0

`define ASR_BIT_JUSTIFY 7
`define ASR_BIT_SIGNED 6
`define ASR_BIT_EIGHT 5

`define ASR_RST_MAIN 8'h00
`define ASR_RST_SC 8'h00
`define ASR_RST_PE 8'h00
`define ASR_RST_RESULT 8'h00

`define ASR_CH_LAST_EXT 5'h07
`define ASR_CH_REF_HIGH 5'h1e
`define ASR_SRC_REF_LOW 2'h0
`define ASR_SRC_REF_HIGH 2'h1
`define ASR_SRC_PIN 2'h2

`define ASR_UNMAPPED_DATA 32'h00000000

`endif

// ---- sim/asr_adc_ctrl_checker.sv ----
// Purpose: Port-level checks of the converter control block
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module asr_adc_ctrl_checker #(
    parameter PIN_N = 8
) (
    input wire i_clk_sys,
    input wire i_srst,
    input wire [3:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    input wire o_avs_waitrequest,
    input wire o_core_start,
    input wire o_core_abort,
    input wire o_irq,
    input wire o_busy,
    input wire [PIN_N-1:0] o_pin_analog_en
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    // Accepted write, only bit 0 lane matters
    wire wrk = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
    a_start_write: assert property (wrk && i_avs_address == 4'h4 |=> o_core_start)
        else $error("no start after status write");
    a_sc_irq_drop: assert property (wrk && i_avs_address == 4'h4 |-> ##2 !o_irq)
        else $error("irq kept after status write");
    a_rd_irq_drop: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address[3] |-> ##2 !o_irq)
        else $error("irq kept after result read");
    a_irq_after_done: assert property ($rose(o_irq) |-> $past(o_busy, 2))
        else $error("irq rose without completion");
    a_irq_reset: assert property (disable iff (1'b0) i_srst |=> !o_irq)
        else $error("irq pending through reset");
    a_zero_no_start: assert property (wrk && i_avs_address == 4'h0 |=> !o_core_start)
        else $error("start after pin or main write");
    a_zero_abort: assert property (wrk && i_avs_address == 4'h0 && o_busy |-> ##[1:2] o_core_abort)
        else $error("no abort after pin or main write");
    a_pe_copy: assert property (wrk && i_avs_address == 4'h0 && !i_avs_writedata[31]
        |=> o_pin_analog_en == $past(i_avs_writedata[PIN_N-1:0]))
        else $error("pin enables not copied");
    // Busy may lag start by the registered stage
    a_start_busy: assert property (o_core_start |-> ##[0:2] o_busy)
        else $error("start without busy");
endmodule // asr_adc_ctrl_checker
bind asr_adc_ctrl asr_adc_ctrl_checker #(.PIN_N(PIN_N)) chk_u (.i_clk_sys(i_clk_sys),
    .i_srst(i_srst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_waitrequest(o_avs_waitrequest),
    .o_core_start(o_core_start), .o_core_abort(o_core_abort), .o_irq(o_irq),
    .o_busy(o_busy), .o_pin_analog_en(o_pin_analog_en));
`default_nettype wire

// ---- sim/asr_adc_ctrl_tb.sv ----
// Purpose: Self-checking bench for the converter control block
// Assumes: Bench is both bus master and analog core
// Notes: Expected reads and core sources are queued, a monitor matches them
`timescale 1ns/1ps
`default_nettype none
module asr_adc_ctrl_tb;
    logic clk = 0, rst = 1, rd = 0, wr = 0, done = 0, wq, st, ab, irq, bsy;
    logic [3:0] adr = 0;
    logic [31:0] wd = 0, rdat;
    logic [9:0] code = 0, c;
    logic [1:0] rsp, src;
    logic [7:0] pe, m, up, lo;
    logic [2:0] ch;
    logic [7:0] md [5] = '{8'h00, 8'h40, 8'h80, 8'hc0, 8'h20};
    logic [7:0] rf [4] = '{8'h08, 8'h1d, 8'h1e, 8'h1f};
    logic [33:0] qr[$];
    logic [1:0] qs[$];
    int fails = 0, compares = 0, seed = 75581;
    always #2.5 clk = ~clk;
    asr_adc_ctrl dut_u (.i_clk_sys(clk), .i_srst(rst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wq), .o_avs_response(rsp), .o_core_start(st), .o_core_abort(ab),
        .o_core_source(src), .o_core_pin(), .i_core_done(done), .i_core_code(code),
        .o_irq(irq), .o_busy(bsy), .o_pin_analog_en(pe));
    task automatic chk(input logic [33:0] e, input logic [33:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t exp %h got %h", $time, e, g);
        end
    endtask
    // Unexpected starts meet an impossible source and so fail
    always @(posedge clk) begin
        if (rd && wq === 1'b0) chk(qr.size() ? qr.pop_front() : '1, {rsp, rdat});
        if (st === 1'b1) chk(qs.size() ? qs.pop_front() : 2'h3, src);
    end
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wq !== 1'b0 && ++n < 99);
        if (n >= 99) fails++;
        wr <= 0;
        rd <= 0;
        @(posedge clk);
    endtask
    task automatic rdx(input logic [3:0] a, input logic [33:0] e);
        qr.push_back(e);
        acc(0, a, 0);
    endtask
    task automatic pulse(input logic [9:0] v);
        repeat (3) @(posedge clk);
        done <= 1;
        code <= v;
        @(posedge clk);
        done <= 0;
        @(posedge clk);
    endtask
    task end_of_test;
        if (fails == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rdx(4'h4, 0);
        rdx(4'h2, 34'h200000000);
        m = 8'($random(seed));
        acc(1, 4'h0, {24'h0, m});
        rdx(4'h0, m);
        for (int i = 0; i < 5; i++) begin
            ch = 3'($random(seed));
            c = m[ch] ? 10'($random(seed)) : 10'h0;
            acc(1, 4'h0, {24'h800000, md[i]});
            qs.push_back(m[ch] ? 2'h2 : 2'h0);
            acc(1, 4'h4, {24'h0, 8'h40 | ch});
            pulse(c);
            rdx(4'h4, 8'hc0 | ch);
            if (md[i][5]) {up, lo} = {c[9:2], 8'h0};
            else if (md[i][7]) {up, lo} = {6'h0, c};
            else {up, lo} = {md[i][6] ^ c[9], c[8:0], 6'h0};
            rdx(4'h8, up);
            rdx(4'hc, lo);
            rdx(4'h4, 8'h40 | ch);
        end
        acc(1, 4'h8, 32'hff);
        rdx(4'h8, up);
        foreach (rf[j]) begin
            qs.push_back(rf[j] == 8'h1e ? 2'h1 : 2'h0);
            acc(1, 4'h4, {24'h0, rf[j]});
        end
        acc(1, 4'h0, {24'h0, m});
        qs.push_back(2'h1);
        acc(1, 4'h4, 32'h3e);
        qs.push_back(2'h1);
        pulse(10'h3ff);
        rdx(4'h8, 8'hff);
        acc(1, 4'h0, {24'h0, m});
        repeat (9) @(posedge clk);
        end_of_test;
    end
    initial begin
        #20000;
        fails++;
        end_of_test;
    end
endmodule // asr_adc_ctrl_tb
`default_nettype wire
